// ### verilog/pcrs_pkg.sv
package pcrs_pkg;
    // widths of the counter, the byte registers, the stack pointer and the bus
    localparam int PC_W         = 21;
    localparam int BYTE_W       = 8;
    localparam int UPPER_W      = 5;
    localparam int PTR_W        = 6;
    localparam int ADR_W        = 8;
    localparam int DAT_W        = 32;
    localparam int SEL_W        = 4;
    // stack depth in normal and in in-circuit debug mode
    localparam int DEPTH_NORMAL = 31;
    localparam int DEPTH_DEBUG  = 35;

    // register byte offsets, one aligned word each
    localparam logic [ADR_W-1:0] OFS_COUNTER_LOW   = 8'h00;
    localparam logic [ADR_W-1:0] OFS_HIGH_LATCH    = 8'h04;
    localparam logic [ADR_W-1:0] OFS_UPPER_LATCH   = 8'h08;
    localparam logic [ADR_W-1:0] OFS_TOP_UPPER     = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_TOP_HIGH      = 8'h10;
    localparam logic [ADR_W-1:0] OFS_TOP_LOW       = 8'h14;
    localparam logic [ADR_W-1:0] OFS_STACK_POINTER = 8'h18;
    localparam logic [ADR_W-1:0] OFS_POWER_STATUS  = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_STACK_CMD     = 8'h20;

    // field positions
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_OVF_BIT  = 1;
    localparam int STAT_UNF_BIT  = 2;
    localparam int CMD_PUSH_BIT  = 0;
    localparam int CMD_POP_BIT   = 1;

    // reset values and fixed constants
    localparam logic [PC_W-1:0]    PC_RESET    = 21'h0_0000;
    localparam logic [PC_W-1:0]    PC_STEP     = 21'h0_0002;
    localparam logic [PC_W-1:0]    PC_ALIGN    = 21'h1F_FFFE;
    localparam logic [BYTE_W-1:0]  LATCH_RESET = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_RESET = 5'h00;
    localparam logic [PTR_W-1:0]   PTR_RESET   = 6'h00;

    // operation chosen for the counter and stack in one cycle
    typedef enum logic [2:0] {
        OP_IDLE    = 3'b000,
        OP_SEQ     = 3'b001,
        OP_JUMP    = 3'b010,
        OP_PUSH    = 3'b011,
        OP_POP     = 3'b100,
        OP_SW_PUSH = 3'b101,
        OP_SW_POP  = 3'b110
    } op_t;
endpackage

// ### verilog/pcrs_ifs.sv
`timescale 1ns/1ps
// register access taken from the bus, one-cycle strobe with its payload
interface reg_access_if;
    import pcrs_pkg::*;
    logic                 acc;
    logic                 we;
    logic                 lane0;
    logic [ADR_W-1:0]     addr;
    logic [BYTE_W-1:0]    wdata;
    modport front (output acc, we, lane0, addr, wdata);
    modport core  (input  acc, we, lane0, addr, wdata);
endinterface

// one write port and one read port of the return stack storage
interface stack_port_if;
    import pcrs_pkg::*;
    logic                 wr_en;
    logic [PTR_W-1:0]     wr_idx;
    logic [PC_W-1:0]      wr_data;
    logic [PTR_W-1:0]     rd_idx;
    logic [PC_W-1:0]      rd_data;
    modport ram  (input  wr_en, wr_idx, wr_data, rd_idx, output rd_data);
    modport core (output wr_en, wr_idx, wr_data, rd_idx, input  rd_data);
endinterface

// ### verilog/wb_front.sv
`timescale 1ns/1ps
module wb_front
    import pcrs_pkg::*;
(
    input  wire logic                 clk_i,      // core clock
    input  wire logic                 rst_i,      // synchronous reset
    input  wire logic                 cyc_i,      // bus cycle
    input  wire logic                 stb_i,      // strobe
    input  wire logic                 we_i,       // write enable
    input  wire logic [ADR_W-1:0]     adr_i,      // byte address
    input  wire logic [DAT_W-1:0]     dat_i,      // write data
    input  wire logic [SEL_W-1:0]     sel_i,      // byte lanes
    output logic                      ack_o,      // registered acknowledge
    reg_access_if.front               acc_o       // access strobe to core
);
    logic ack_reg;

    // one access per request; the ack blocks a second take in the ack cycle
    assign acc_o.acc   = cyc_i && stb_i && !ack_reg;
    assign acc_o.we    = we_i;
    assign acc_o.lane0 = sel_i[0];
    assign acc_o.addr  = {adr_i[ADR_W-1:2], 2'b00};
    assign acc_o.wdata = dat_i[BYTE_W-1:0];
    assign ack_o       = ack_reg;

    // every address answers, unmapped ones with zero data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= cyc_i && stb_i && !ack_reg;
        end
    end
endmodule

// ### verilog/return_stack_ram.sv
`timescale 1ns/1ps
module return_stack_ram
    import pcrs_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEBUG             // storage entries
)(
    input  wire logic                 clk_i,      // core clock
    stack_port_if.ram                 port_io     // write and read port
);
    // storage lies outside program and data space; no reset, like a ram
    logic [PC_W-1:0] mem [DEPTH];

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << PTR_W) - 1) begin
            $error("return_stack_ram: DEPTH out of range");
        end
    end

    // asynchronous read keeps the top entry visible in the same cycle
    assign port_io.rd_data = (int'(port_io.rd_idx) < DEPTH) ? mem[port_io.rd_idx] : PC_RESET;

    always_ff @(posedge clk_i) begin
        if (port_io.wr_en && int'(port_io.wr_idx) < DEPTH) begin
            mem[port_io.wr_idx] <= port_io.wr_data;
        end
    end
endmodule

// ### verilog/program_counter_return_stack.sv
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - 21-bit fetch counter in three byte registers
// - low byte direct; high byte only via latch
// - upper byte hidden; loaded only via latch
// - low byte write copies both latches in
// - low byte read copies high, upper to latches
// - bit zero held low; advance by two
// - calls, jumps, branches load target, ignore latches
// - stack holds up to 31 nested calls, 35 in debug mode
// - push on call and interrupt acknowledge
// - pop into counter on any return
// - latches untouched by call and return
// - 31 entries normally, 35 in debug mode
// - stack storage separate from program, data space
// - pointer readable, writable; software push and pop
// - push increments pointer, then writes entry
// - pop reads entry, then decrements pointer
// - pointer zero after reset, no entry there
// - status shows full, overflow and underflow
// - top window shows only the selected entry
module program_counter_return_stack
    import pcrs_pkg::*;
#(
    parameter int NORMAL_DEPTH = DEPTH_NORMAL,            // entries, normal mode
    parameter int DEBUG_DEPTH  = DEPTH_DEBUG              // entries, debug mode
)(
    input  wire logic                        clk_i,                 // core clock
    input  wire logic                        rst_i,                 // synchronous reset
    input  wire logic                        wb_cyc_i,              // bus cycle
    input  wire logic                        wb_stb_i,              // bus strobe
    input  wire logic                        wb_we_i,               // bus write
    input  wire logic [pcrs_pkg::ADR_W-1:0]  wb_adr_i,              // byte address
    input  wire logic [pcrs_pkg::DAT_W-1:0]  wb_dat_i,              // write data
    input  wire logic [pcrs_pkg::SEL_W-1:0]  wb_sel_i,              // byte lanes
    output logic      [pcrs_pkg::DAT_W-1:0]  wb_dat_o,              // read data
    output logic                             wb_ack_o,              // acknowledge
    input  wire logic                        advance_i,             // sequential step
    input  wire logic                        jump_i,                // goto or branch
    input  wire logic                        call_i,                // call or relative call
    input  wire logic [pcrs_pkg::PC_W-1:0]   jump_target_i,         // target address
    input  wire logic                        irq_ack_i,             // interrupt taken
    input  wire logic [pcrs_pkg::PC_W-1:0]   irq_vector_i,          // interrupt vector
    input  wire logic                        return_i,              // any return
    input  wire logic                        in_circuit_debug_mode_i, // deep stack
    output logic      [pcrs_pkg::PC_W-1:0]   fetch_addr_o,          // fetch address
    output logic      [pcrs_pkg::PTR_W-1:0]  stack_ptr_o,           // stack pointer
    output logic                             stack_full_o,          // full flag
    output logic                             stack_overflow_o,      // overflow flag
    output logic                             stack_underflow_o      // underflow flag
);
    import pcrs_pkg::*;

    initial begin
        if (NORMAL_DEPTH < 1 || NORMAL_DEPTH > DEBUG_DEPTH || DEBUG_DEPTH > (1 << PTR_W) - 1) begin
            $error("program_counter_return_stack: bad depth parameters");
        end
    end

    localparam logic [PTR_W-1:0] LIMIT_NORMAL = PTR_W'(NORMAL_DEPTH);
    localparam logic [PTR_W-1:0] LIMIT_DEBUG  = PTR_W'(DEBUG_DEPTH);

    reg_access_if acc_bus ();
    stack_port_if stk ();

    logic [PC_W-1:0]    pc_reg;
    logic [PC_W-1:0]    pc_next;
    logic [BYTE_W-1:0]  high_latch_reg;
    logic [UPPER_W-1:0] upper_latch_reg;
    logic [PTR_W-1:0]   ptr_reg;
    logic [PTR_W-1:0]   ptr_next;
    logic               full_reg;
    logic               overflow_reg;
    logic               underflow_reg;
    logic [DAT_W-1:0]   rdata_reg;
    logic [PTR_W-1:0]   limit;
    logic               at_full;
    logic               at_empty;
    logic               push_try;
    logic               pop_try;
    logic               push_ok;
    logic               pop_ok;
    logic [PC_W-1:0]    top_word;
    logic               sw_wr;
    logic               sw_rd;
    logic [ADR_W-1:0]   reg_addr;
    logic [BYTE_W-1:0]  wbyte;
    logic               hw_busy;
    op_t                op;

    wb_front u_front (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .adr_i (wb_adr_i),
        .dat_i (wb_dat_i),
        .sel_i (wb_sel_i),
        .ack_o (wb_ack_o),
        .acc_o (acc_bus)
    );

    return_stack_ram #(
        .DEPTH (DEBUG_DEPTH)
    ) u_ram (
        .clk_i   (clk_i),
        .port_io (stk)
    );

    // decoded software access; a write needs the low byte lane
    assign sw_wr    = acc_bus.acc && acc_bus.we && acc_bus.lane0;
    assign sw_rd    = acc_bus.acc && !acc_bus.we;
    assign reg_addr = acc_bus.addr;
    assign wbyte    = acc_bus.wdata;

    // depth follows the mode; a pointer above the current mode's limit still counts as full
    assign limit    = in_circuit_debug_mode_i ? LIMIT_DEBUG : LIMIT_NORMAL;
    assign at_full  = (ptr_reg >= limit);
    assign at_empty = (ptr_reg == PTR_RESET);

    // operation select: interrupt and call outrank return, jump and step
    always_comb begin
        op = OP_IDLE;
        if (irq_ack_i || call_i) begin
            op = OP_PUSH;
        end else if (return_i) begin
            op = OP_POP;
        end else if (jump_i) begin
            op = OP_JUMP;
        end else if (advance_i) begin
            op = OP_SEQ;
        end else if (sw_wr && reg_addr == OFS_STACK_CMD && wbyte[CMD_PUSH_BIT]) begin
            op = OP_SW_PUSH;
        end else if (sw_wr && reg_addr == OFS_STACK_CMD && wbyte[CMD_POP_BIT]) begin
            op = OP_SW_POP;
        end
    end

    assign push_try = (op == OP_PUSH) || (op == OP_SW_PUSH);
    assign pop_try  = (op == OP_POP) || (op == OP_SW_POP);
    assign push_ok  = push_try && !at_full;
    assign pop_ok   = pop_try && !at_empty;
    assign hw_busy  = (op != OP_IDLE);

    // pointer value n selects storage slot n-1; position zero has no slot
    assign stk.rd_idx = ptr_reg - PTR_W'(1);
    assign top_word   = at_empty ? PC_RESET : stk.rd_data;

    // stack write: a push fills the slot of the incremented pointer
    always_comb begin
        stk.wr_en   = 1'b0;
        stk.wr_idx  = ptr_reg;
        stk.wr_data = pc_reg;
        if (push_ok) begin
            stk.wr_en   = 1'b1;
            stk.wr_idx  = ptr_reg;
            stk.wr_data = pc_reg;
        end else if (sw_wr && !at_empty && !pop_try) begin
            // top window writes modify one byte of the selected entry
            stk.wr_idx  = ptr_reg - PTR_W'(1);
            stk.wr_data = top_word;
            case (reg_addr)
                OFS_TOP_UPPER: begin
                    stk.wr_en   = 1'b1;
                    stk.wr_data = {wbyte[UPPER_W-1:0], top_word[15:0]};
                end
                OFS_TOP_HIGH: begin
                    stk.wr_en   = 1'b1;
                    stk.wr_data = {top_word[20:16], wbyte, top_word[7:0]};
                end
                OFS_TOP_LOW: begin
                    stk.wr_en   = 1'b1;
                    stk.wr_data = {top_word[20:8], wbyte};
                end
                default: begin
                    stk.wr_en   = 1'b0;
                end
            endcase
        end
    end

    // counter next value; the hidden bytes change only by these paths
    always_comb begin
        pc_next = pc_reg;
        case (op)
            OP_SEQ: begin
                pc_next = (pc_reg + PC_STEP) & PC_ALIGN;
            end
            OP_JUMP: begin
                pc_next = jump_target_i & PC_ALIGN;
            end
            OP_PUSH: begin
                pc_next = (irq_ack_i ? irq_vector_i : jump_target_i) & PC_ALIGN;
            end
            OP_POP: begin
                pc_next = top_word & PC_ALIGN;
            end
            OP_IDLE: begin
                if (sw_wr && reg_addr == OFS_COUNTER_LOW) begin
                    pc_next = {upper_latch_reg, high_latch_reg, wbyte[7:1], 1'b0};
                end
            end
            default: begin
                pc_next = pc_reg;
            end
        endcase
    end

    // program counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= PC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // latches: software writes, or a low byte read snapshots the hidden bytes
    // no call or return path reaches them, so a pushed frame keeps its latches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_latch_reg  <= LATCH_RESET;
            upper_latch_reg <= UPPER_RESET;
        end else if (sw_rd && reg_addr == OFS_COUNTER_LOW) begin
            high_latch_reg  <= pc_reg[15:8];
            upper_latch_reg <= pc_reg[20:16];
        end else if (sw_wr && reg_addr == OFS_HIGH_LATCH) begin
            high_latch_reg  <= wbyte;
        end else if (sw_wr && reg_addr == OFS_UPPER_LATCH) begin
            upper_latch_reg <= wbyte[UPPER_W-1:0];
        end
    end

    // pointer next: push increments, pop decrements, software may load it
    always_comb begin
        ptr_next = ptr_reg;
        if (push_ok) begin
            ptr_next = ptr_reg + PTR_W'(1);
        end else if (pop_ok) begin
            ptr_next = ptr_reg - PTR_W'(1);
        end else if (!hw_busy && sw_wr && reg_addr == OFS_STACK_POINTER) begin
            // a value past the current mode's depth is clamped to that mode's limit
            ptr_next = (wbyte[PTR_W-1:0] > limit) ? limit : wbyte[PTR_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_reg <= PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // sticky status; software clears by writing ones, a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_reg      <= 1'b0;
            overflow_reg  <= 1'b0;
            underflow_reg <= 1'b0;
        end else begin
            if (push_ok && ptr_next == limit) begin
                full_reg <= 1'b1;
            end else if (sw_wr && reg_addr == OFS_POWER_STATUS && wbyte[STAT_FULL_BIT]) begin
                full_reg <= 1'b0;
            end
            if (push_try && at_full) begin
                overflow_reg <= 1'b1;
            end else if (sw_wr && reg_addr == OFS_POWER_STATUS && wbyte[STAT_OVF_BIT]) begin
                overflow_reg <= 1'b0;
            end
            if (pop_try && at_empty) begin
                underflow_reg <= 1'b1;
            end else if (sw_wr && reg_addr == OFS_POWER_STATUS && wbyte[STAT_UNF_BIT]) begin
                underflow_reg <= 1'b0;
            end
        end
    end

    // read data, registered with the ack; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (sw_rd) begin
            case (reg_addr)
                OFS_COUNTER_LOW:   rdata_reg <= DAT_W'(pc_reg[7:0]);
                OFS_HIGH_LATCH:    rdata_reg <= DAT_W'(high_latch_reg);
                OFS_UPPER_LATCH:   rdata_reg <= DAT_W'(upper_latch_reg);
                OFS_TOP_UPPER:     rdata_reg <= DAT_W'(top_word[20:16]);
                OFS_TOP_HIGH:      rdata_reg <= DAT_W'(top_word[15:8]);
                OFS_TOP_LOW:       rdata_reg <= DAT_W'(top_word[7:0]);
                OFS_STACK_POINTER: rdata_reg <= DAT_W'(ptr_reg);
                OFS_POWER_STATUS:  rdata_reg <= DAT_W'({underflow_reg, overflow_reg, full_reg});
                default:           rdata_reg <= '0;
            endcase
        end
    end

    assign wb_dat_o          = rdata_reg;
    assign fetch_addr_o      = pc_reg;
    assign stack_ptr_o       = ptr_reg;
    assign stack_full_o      = full_reg;
    assign stack_overflow_o  = overflow_reg;
    assign stack_underflow_o = underflow_reg;

    // ---- checks ----
    // helper copies so that $past sees plain signals
    logic [BYTE_W-1:0]  pc_high_byte;
    logic [UPPER_W-1:0] pc_upper_byte;
    logic [PC_W-1:0]    target_aligned;
    logic               low_write;
    logic               low_read;
    assign pc_high_byte   = pc_reg[15:8];
    assign pc_upper_byte  = pc_reg[20:16];
    assign target_aligned = jump_target_i & PC_ALIGN;
    assign low_write      = (op == OP_IDLE) && sw_wr && reg_addr == OFS_COUNTER_LOW;
    assign low_read       = sw_rd && reg_addr == OFS_COUNTER_LOW;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_align_bit_low: assert property (fetch_addr_o[0] == 1'b0)
        else $error("fetch address bit 0 is set");
    chk_sequential_step: assert property ((op == OP_SEQ) |=> fetch_addr_o == $past(pc_reg) + PC_STEP)
        else $error("sequential step is not two");
    chk_jump_direct: assert property ((op == OP_JUMP) |=> fetch_addr_o == $past(target_aligned))
        else $error("jump did not load target");
    chk_latch_call_hold: assert property ((push_try || pop_try) |=> $stable(high_latch_reg) && $stable(upper_latch_reg))
        else $error("latch changed on call or return");
    chk_push_pointer_up: assert property (push_ok |=> stack_ptr_o == $past(ptr_reg) + PTR_W'(1))
        else $error("push did not raise pointer");
    chk_pop_restore_pc: assert property ((op == OP_POP) && pop_ok |=> fetch_addr_o == ($past(top_word) & PC_ALIGN) && stack_ptr_o == $past(ptr_reg) - PTR_W'(1))
        else $error("pop did not restore counter");
    chk_overflow_hold: assert property (push_try && at_full |=> stack_overflow_o && $stable(ptr_reg))
        else $error("overflow not flagged or pointer moved");
    chk_underflow_flag: assert property (pop_try && at_empty |=> stack_underflow_o && stack_ptr_o == PTR_RESET)
        else $error("underflow not flagged");
    chk_pointer_limit: assert property (stack_ptr_o <= LIMIT_DEBUG)
        else $error("pointer past deepest entry");
    chk_low_write_load: assert property (low_write |=> fetch_addr_o[20:8] == {$past(upper_latch_reg), $past(high_latch_reg)})
        else $error("low byte write missed latches");
    chk_low_read_snap: assert property (low_read |=> high_latch_reg == $past(pc_high_byte) && upper_latch_reg == $past(pc_upper_byte))
        else $error("low byte read missed snapshot");
    chk_reset_pointer: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> stack_ptr_o == PTR_RESET)
        else $error("pointer not zero after reset");

    cov_call_then_return: cover property ((op == OP_PUSH) ##[1:20] (op == OP_POP) && pop_ok);
    cov_overflow_seen:    cover property (push_try && at_full);
    cov_low_byte_write:   cover property (low_write);
    cov_debug_depth_push: cover property (push_ok && in_circuit_debug_mode_i && ptr_reg >= LIMIT_NORMAL);
endmodule

// ### verification/cpu_decoder_model.sv
`timescale 1ns/1ps
// stands in for the instruction decoder: one operation per cycle of op_i
module cpu_decoder_model
    import pcrs_pkg::*;
(
    input  wire pcrs_pkg::op_t op_i,       // operation chosen
    input  wire logic          irq_i,      // pending interrupt
    input  wire logic          gie_i,      // global_irq_enable
    output logic               advance_o,  // sequential step
    output logic               jump_o,     // goto or branch
    output logic               call_o,     // call
    output logic               return_o,   // any return
    output logic               irq_ack_o   // interrupt taken
);
    // decode is immediate, so the core sees the op in the cycle it is issued
    assign advance_o = (op_i == OP_SEQ);
    assign jump_o    = (op_i == OP_JUMP);
    assign call_o    = (op_i == OP_PUSH);
    assign return_o  = (op_i == OP_POP);
    // no interrupt taken while the global enable gie_i is low
    assign irq_ack_o = irq_i && gie_i;
endmodule

// ### verification/program_counter_return_stack_tb_top.sv
`timescale 1ns/1ps
module program_counter_return_stack_tb_top;
    import pcrs_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0, we = 1'b0, irq = 1'b0, global_irq_enable = 1'b1, dbg = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rd, dat_o;
    logic [20:0] tgt = 21'h0_0000, fetch;
    op_t         op = OP_IDLE;
    logic        ack, adv, jmp, cal, ret, iak, full, ovf, unf;
    logic [5:0]  ptr;
    int          num_errors = 0, tests_run = 0, cycles = 0;

    always #2.5 clk_i = ~clk_i;
    // a hang ends the run through the normal report
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    cpu_decoder_model PART (.op_i(op), .irq_i(irq), .gie_i(global_irq_enable), .advance_o(adv),
        .jump_o(jmp), .call_o(cal), .return_o(ret), .irq_ack_o(iak));
    program_counter_return_stack DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'h1),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .advance_i(adv), .jump_i(jmp), .call_i(cal),
        .jump_target_i(tgt), .irq_ack_i(iak), .irq_vector_i(21'h0_0008), .return_i(ret),
        .in_circuit_debug_mode_i(dbg), .fetch_addr_o(fetch), .stack_ptr_o(ptr),
        .stack_full_o(full), .stack_overflow_o(ovf), .stack_underflow_o(unf));

    task test_done;
        $display("errors %0d tests %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %0t got %h expected %h", $time, g, e);
            num_errors++;
        end
    endtask
    // one op for one cycle, outputs judged at the falling edge once settled
    task cpu(input op_t o, input logic [20:0] t, input logic i);
        @(posedge clk_i);
        op <= o;
        tgt <= t;
        irq <= i;
        @(posedge clk_i);
        op <= OP_IDLE;
        irq <= 1'b0;
        @(negedge clk_i);
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        req <= 1'b0;
        @(negedge clk_i);
    endtask
    task reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task t_reset;
        chk(fetch, 0);
        chk(ptr, 0);
        wb(0, 8'h1C, 0);
        chk(rd, 0);
        wb(0, 8'h3C, 0);
        chk(rd, 0);
        $display("test reset done");
    endtask
    task t_counter;
        repeat (3) cpu(OP_SEQ, 0, 0);
        chk(fetch, 21'h0_0006);
        wb(1, 8'h04, 32'h0000_0034);
        wb(1, 8'h08, 32'h0000_0005);
        cpu(OP_JUMP, 21'h1_2345, 0);
        chk(fetch, 21'h1_2344);
        wb(1, 8'h00, 32'h0000_0057);
        chk(fetch, 21'h5_3456);
        cpu(OP_JUMP, 21'h0_ABCD, 0);
        wb(0, 8'h00, 0);
        chk(rd, 32'h0000_00CC);
        wb(0, 8'h04, 0);
        chk(rd, 32'h0000_00AB);
        wb(0, 8'h08, 0);
        chk(rd, 0);
        $display("test counter done");
    endtask
    task t_call;
        cpu(OP_PUSH, 21'h0_0100, 0);
        chk({ptr, fetch}, {6'h01, 21'h0_0100});
        @(posedge clk_i);
        global_irq_enable <= 1'b0;
        wb(0, 8'h14, 0);
        chk(rd, 32'h0000_00CC);
        wb(0, 8'h10, 0);
        chk(rd, 32'h0000_00AB);
        @(posedge clk_i) global_irq_enable <= 1'b1;
        cpu(OP_IDLE, 0, 1);
        chk({ptr, fetch}, {6'h02, 21'h0_0008});
        cpu(OP_POP, 0, 0);
        chk({ptr, fetch}, {6'h01, 21'h0_0100});
        cpu(OP_POP, 0, 0);
        chk({ptr, fetch}, {6'h00, 21'h0_ABCC});
        wb(0, 8'h04, 0);
        chk(rd, 32'h0000_00AB);
        wb(1, 8'h20, 32'h0000_0001);
        chk(ptr, 1);
        wb(1, 8'h14, 32'h0000_0012);
        cpu(OP_POP, 0, 0);
        chk({ptr, fetch}, {6'h00, 21'h0_AB12});
        wb(1, 8'h20, 32'h0000_0001);
        wb(1, 8'h20, 32'h0000_0002);
        chk({ptr, fetch}, {6'h00, 21'h0_AB12});
        wb(1, 8'h18, 32'h0000_0003);
        wb(0, 8'h18, 0);
        chk(rd, 3);
        $display("test call done");
    endtask
    // fill to the mode's depth, push once too many, drain, pop once too many
    task t_depth(input logic m, input int d);
        @(posedge clk_i);
        dbg <= m;
        reset();
        for (int i = 0; i < d; i++) cpu(OP_PUSH, 21'(i * 2), 0);
        chk({full, ovf, ptr}, {2'b10, 6'(d)});
        wb(0, 8'h14, 0);
        chk(rd, 32'((d - 2) * 2));
        cpu(OP_PUSH, 21'h0_0040, 0);
        chk({ovf, ptr}, {1'b1, 6'(d)});
        wb(0, 8'h1C, 0);
        chk(rd, 3);
        wb(0, 8'h14, 0);
        chk(rd, 32'((d - 2) * 2));
        for (int i = 0; i <= d; i++) cpu(OP_POP, 0, 0);
        chk({unf, ptr, fetch}, {1'b1, 27'h0});
        wb(1, 8'h1C, 32'h0000_0007);
        wb(0, 8'h1C, 0);
        chk(rd, 0);
        $display("test depth done");
    endtask

    initial begin
        reset();
        t_reset();
        t_counter();
        t_call();
        t_depth(1'b0, 31);
        t_depth(1'b1, 35);
        test_done();
    end
endmodule
